// ---- rcs_regs.sv ----
// Configuration and status register bank of the buck regulator digital interface.
//
// Notes on behaviour
// - Decode registers other than the page register only on command page zero.
// - Limit scale codes: 50, 75, 100 percent.
// - Writable seven-bit interface address, used for matching.
// - Configuration code read only; writes ignored.
// - OTP checksum sixteen bits, read only.
// - Capture packet check of latest write.
// - OTP error flags in bits two..zero.
// - Tuning registers accessible only with key E1.
// - Sense gain ratio code, times sense scale.
// - Ramp transconductance ratio code, times ramp scale.
// - Bit zero picks feedback divider one/two.
// - Bit seven set disables continuous adaptive on-time.
// - Bit six set disables soft-start adaptive on-time.
// - Bit five doubles sense gain multiplier.
// - Bit four doubles ramp multiplier.
// - Bit three lengthens 15ns minimum off time.
// - On-time ratio code field bits two..zero.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "rcs_consts.svh"
module rcs_regs
  import rcs_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Interface frame facts from the link engine.
  input wire logic [6:0] frame_addr,
  input wire logic wr_done,
  input wire logic [7:0] wr_pec,
  output logic addr_match,
  // Read-only sources from the OTP loader.
  input wire logic [7:0] configuration_code,
  input wire logic [15:0] otp_checksum,
  input wire logic boot_load_checksum_error,
  input wire logic boot_load_indicator_error,
  input wire logic otp_store_error,
  // Settings for the analog loop.
  output logic [1:0] current_limit_scaling,
  output logic [2:0] sense_gain_ratio,
  output logic [1:0] ramp_transconductance_ratio,
  output logic feedback_transconductance_divider,
  output logic adaptive_on_time_disable_continuous,
  output logic adaptive_on_time_disable_soft_start,
  output logic sense_gain_multiplier,
  output logic ramp_transconductance_multiplier,
  output logic min_off_extend,
  output logic [2:0] min_on_ratio,
  output logic tuning_unlocked,
  output logic invalid_command
);

  ////////////////////////////////////////////////////////////////////////////

  rcs_state_s s_q;
  rcs_state_s s_d;

  // Decoding shared by read and write paths.
  function automatic logic on_page(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] o);
    on_page = (pg == `RCS_PAGE_MAIN) && (a == o);
  endfunction

  logic unlocked;
  assign unlocked = (s_q.unlock == `RCS_UNLOCK_KEY);

  // Next-state logic: writes, captures and read data in one place.
  always_comb begin
    s_d = s_q;
    s_d.bad_cmd = 1'b0;
    s_d.rdata = 16'h0000;
    // The packet check of a finished write is captured even during a bus write.
    if (wr_done) begin
      s_d.pkt_check = wr_pec;
    end
    if (reg_wr) begin
      if (reg_addr == `RCS_OFS_PAGE) begin
        s_d.page = reg_wdata[7:0];
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_ILIM)) begin
        // An unused code would leave the limit undefined, so it is refused.
        if (reg_wdata[1:0] == `RCS_ILIM_BAD) begin
          s_d.bad_cmd = 1'b1;
        end else begin
          s_d.ilim = reg_wdata[1:0];
        end
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_ADDR)) begin
        s_d.addr = reg_wdata[6:0];
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_UNLOCK)) begin
        s_d.unlock = reg_wdata[7:0];
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_SUMMING) && unlocked) begin
        s_d.summing = reg_wdata[5:0];
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_ONOFF) && unlocked) begin
        s_d.onoff = reg_wdata[7:0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `RCS_OFS_PAGE) begin
        s_d.rdata = {8'h00, s_q.page};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_ILIM)) begin
        s_d.rdata = {14'h0000, s_q.ilim};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_ADDR)) begin
        s_d.rdata = {9'h000, s_q.addr};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_CFGCODE)) begin
        s_d.rdata = {8'h00, configuration_code};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_CHKSUM)) begin
        s_d.rdata = otp_checksum;
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_PKTCHK)) begin
        s_d.rdata = {8'h00, s_q.pkt_check};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_OTPERR)) begin
        s_d.rdata = {13'h0000, boot_load_checksum_error, boot_load_indicator_error,
                     otp_store_error};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_UNLOCK)) begin
        s_d.rdata = {8'h00, s_q.unlock};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_SUMMING) && unlocked) begin
        s_d.rdata = {10'h000, s_q.summing};
      end else if (on_page(s_q.page, reg_addr, `RCS_OFS_ONOFF) && unlocked) begin
        s_d.rdata = {8'h00, s_q.onoff};
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.page <= `RCS_PAGE_MAIN;
      s_q.ilim <= `RCS_ILIM_RST;
      s_q.addr <= `RCS_ADDR_RST;
      s_q.pkt_check <= 8'h00;
      s_q.unlock <= `RCS_UNLOCK_RST;
      s_q.summing <= `RCS_SUMMING_RST;
      s_q.onoff <= `RCS_ONOFF_RST;
      s_q.bad_cmd <= 1'b0;
      s_q.rdata <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Outputs straight from the state; the loop sees a setting the cycle after a write.
  assign reg_rdata = s_q.rdata;
  assign addr_match = (frame_addr == s_q.addr);
  assign current_limit_scaling = s_q.ilim;
  assign sense_gain_ratio = s_q.summing[5:3];
  assign ramp_transconductance_ratio = s_q.summing[2:1];
  assign feedback_transconductance_divider = s_q.summing[0];
  assign adaptive_on_time_disable_continuous = s_q.onoff[`RCS_BIT_AOT_CONT];
  assign adaptive_on_time_disable_soft_start = s_q.onoff[`RCS_BIT_AOT_SS];
  assign sense_gain_multiplier = s_q.onoff[`RCS_BIT_SENSE_SCALE];
  assign ramp_transconductance_multiplier = s_q.onoff[`RCS_BIT_RAMP_SCALE];
  assign min_off_extend = s_q.onoff[`RCS_BIT_MIN_OFF];
  assign min_on_ratio = s_q.onoff[2:0];
  assign tuning_unlocked = unlocked;
  assign invalid_command = s_q.bad_cmd;

  ////////////////////////////////////////////////////////////////////////////

  // Checks on the bank.
  AST_ILIM_NEVER_BAD: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_q.ilim != `RCS_ILIM_BAD) else $error("limit scale holds invalid code");
  AST_BAD_KEEPS: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && on_page(s_q.page, reg_addr, `RCS_OFS_ILIM) && reg_wdata[1:0] == `RCS_ILIM_BAD
    |=> invalid_command && $stable(current_limit_scaling))
    else $error("invalid limit write not rejected");
  AST_LOCKED_TUNE: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && !unlocked && reg_addr == `RCS_OFS_ONOFF |=> $stable(s_q.onoff))
    else $error("locked tuning register changed");
  AST_LOCKED_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && !unlocked && reg_addr == `RCS_OFS_SUMMING |=> reg_rdata == 16'h0000)
    else $error("locked tuning register readable");
  AST_PAGE_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && s_q.page != `RCS_PAGE_MAIN && reg_addr == `RCS_OFS_ADDR |=> $stable(s_q.addr))
    else $error("write decoded off page zero");
  AST_PEC_CAPTURE: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_done |=> s_q.pkt_check == $past(wr_pec)) else $error("packet check not captured");
  AST_CHKSUM_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && on_page(s_q.page, reg_addr, `RCS_OFS_CHKSUM) |=> reg_rdata == $past(otp_checksum))
    else $error("checksum read mismatch");
  AST_OTPERR_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && on_page(s_q.page, reg_addr, `RCS_OFS_OTPERR)
    |=> reg_rdata[15:3] == 13'h0000 && reg_rdata[2] == $past(boot_load_checksum_error))
    else $error("otp flags read wrong");
  AST_ADDR_RESERVED: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && on_page(s_q.page, reg_addr, `RCS_OFS_ADDR) |=> reg_rdata[15:7] == 9'h000)
    else $error("reserved address bit not zero");
  AST_ADDR_MATCH: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && on_page(s_q.page, reg_addr, `RCS_OFS_ADDR) ##1 frame_addr == $past(reg_wdata[6:0])
    |-> addr_match) else $error("address write not matched");
  AST_CFG_RO: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && on_page(s_q.page, reg_addr, `RCS_OFS_CFGCODE)
    |=> reg_rdata == {8'h00, $past(configuration_code)}) else $error("config code wrong");
  // Reads off page zero must never expose the bank, even for a valid command code.
  AST_PAGE_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && s_q.page != `RCS_PAGE_MAIN && reg_addr == `RCS_OFS_ILIM |=> reg_rdata == 16'h0000)
    else $error("read decoded off page zero");
  // Read data stand for one cycle only; an idle bus reads as zero.
  AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data left standing");
  AST_LOCKED_READ_ONOFF: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && !unlocked && reg_addr == `RCS_OFS_ONOFF |=> reg_rdata == 16'h0000)
    else $error("locked on-time register readable");
  AST_SCALE_BITS: assert property (@(posedge sys_clk) disable iff (!resetn)
    sense_gain_multiplier == s_q.onoff[5] && min_off_extend == s_q.onoff[3])
    else $error("tuning bit mapping wrong");
  COV_UNLOCK: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(unlocked));
  COV_BAD: cover property (@(posedge sys_clk) disable iff (!resetn) invalid_command);
  COV_TUNE_WR: cover property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && unlocked && reg_addr == `RCS_OFS_SUMMING);
  COV_PAGE_OFF: cover property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && s_q.page != `RCS_PAGE_MAIN);

endmodule

// ---- rcs_consts.svh ----
// Register offsets, field positions, reset values and keys for the regulator register bank.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_OFS_ILIM 8'hD2
`define RCS_OFS_ADDR 8'hD3
`define RCS_OFS_CFGCODE 8'hD4
`define RCS_OFS_CHKSUM 8'hD5
`define RCS_OFS_PKTCHK 8'hD6
`define RCS_OFS_OTPERR 8'hD8
`define RCS_OFS_UNLOCK 8'hDB
`define RCS_OFS_SUMMING 8'hDC
`define RCS_OFS_ONOFF 8'hDD
`define RCS_OFS_PAGE 8'h00
`define RCS_PAGE_MAIN 8'h00
`define RCS_ILIM_RST 2'h0
`define RCS_ILIM_BAD 2'h3
`define RCS_ADDR_RST 7'h03
`define RCS_UNLOCK_KEY 8'hE1
`define RCS_UNLOCK_RST 8'h00
`define RCS_SUMMING_RST 6'h00
`define RCS_ONOFF_RST 8'h00
`define RCS_MIN_OFF_BASE_NS 15
`define RCS_BIT_AOT_CONT 7
`define RCS_BIT_AOT_SS 6
`define RCS_BIT_SENSE_SCALE 5
`define RCS_BIT_RAMP_SCALE 4
`define RCS_BIT_MIN_OFF 3
`endif

// ---- rcs_pkg.sv ----
// Types shared by the regulator register bank.
package rcs_pkg;
  typedef enum logic [1:0] {
    RCS_LIM_HALF = 2'h0,
    RCS_LIM_THREE_Q = 2'h1,
    RCS_LIM_FULL = 2'h2
  } rcs_limit_e;
  typedef struct packed {
    logic [7:0] page;
    logic [1:0] ilim;
    logic [6:0] addr;
    logic [7:0] pkt_check;
    logic [7:0] unlock;
    logic [5:0] summing;
    logic [7:0] onoff;
    logic bad_cmd;
    logic [15:0] rdata;
  } rcs_state_s;
endpackage

// ---- rcs_host_model.sv ----
// Link engine stand-in that reports finished write frames to the register bank.
`timescale 1ns/100ps
module rcs_host_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Request from the bench.
  input wire logic send,
  input wire logic [7:0] pec_in,
  // Frame report towards the bank.
  output logic wr_done,
  output logic [7:0] wr_pec
);
  ////////////////////////////////////////////////////////////////////////////////
  // The check byte toggles outside its pulse, so a bank that samples late reads junk.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_done <= 1'b0;
      wr_pec <= 8'h00;
    end else if (send) begin
      wr_done <= 1'b1;
      wr_pec <= pec_in;
    end else begin
      wr_done <= 1'b0;
      wr_pec <= ~wr_pec;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the regulator register bank.
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
  logic [7:0] reg_addr = 8'h00, pec_in = 8'h00, configuration_code = 8'hA7;
  logic [15:0] reg_wdata = 16'h0000, otp_checksum = 16'hBEEF, reg_rdata;
  logic [6:0] frame_addr = 7'h03;
  logic [2:0] otp_flags = 3'b101, sense_gain_ratio, min_on_ratio;
  logic [1:0] current_limit_scaling, ramp_transconductance_ratio;
  logic wr_done, addr_match, feedback_transconductance_divider, min_off_extend;
  logic adaptive_on_time_disable_continuous, adaptive_on_time_disable_soft_start;
  logic sense_gain_multiplier, ramp_transconductance_multiplier;
  logic tuning_unlocked, invalid_command;
  logic [7:0] wr_pec;
  int fail_count = 0, check_count = 0;
  rcs_host_model i_rcs_host_model (.sys_clk, .resetn, .send, .pec_in, .wr_done, .wr_pec);
  rcs_regs i_rcs_regs (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .frame_addr, .wr_done, .wr_pec, .addr_match, .configuration_code,
    .otp_checksum, .boot_load_checksum_error(otp_flags[2]),
    .boot_load_indicator_error(otp_flags[1]), .otp_store_error(otp_flags[0]),
    .current_limit_scaling, .sense_gain_ratio, .ramp_transconductance_ratio,
    .feedback_transconductance_divider, .adaptive_on_time_disable_continuous,
    .adaptive_on_time_disable_soft_start, .sense_gain_multiplier,
    .ramp_transconductance_multiplier, .min_off_extend, .min_on_ratio,
    .tuning_unlocked, .invalid_command);
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz.
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One-cycle write; returns just after the edge that takes it, when its effect shows.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic t_reset;
    rchk(8'hD2, 16'h0000);
    rchk(8'hD3, 16'h0003);
    chk(addr_match, 1'b1);
    rchk(8'hDC, 16'h0000);
  endtask
  // Every valid limit code with reserved bits set, then the refused code.
  task automatic t_limit;
    for (int c = 0; c < 3; c++) begin
      wr(8'hD2, {8'h00, 6'h3F, c[1:0]});
      chk(current_limit_scaling, c[1:0]);
      rchk(8'hD2, {14'h0000, c[1:0]});
    end
    wr(8'hD2, 16'h0003);
    chk(invalid_command, 1'b1);
    chk(current_limit_scaling, 2'h2);
  endtask
  // The frame address leads the write, so the match must follow the write itself.
  task automatic t_addr;
    @(posedge sys_clk);
    frame_addr <= 7'h55;
    #1;
    chk(addr_match, 1'b0);
    wr(8'hD3, 16'h00D5);
    chk(addr_match, 1'b1);
    rchk(8'hD3, 16'h0055);
    @(posedge sys_clk);
    frame_addr <= 7'h03;
    #1;
    chk(addr_match, 1'b0);
  endtask
  task automatic t_ro;
    wr(8'hD4, 16'h00FF);
    rchk(8'hD4, 16'h00A7);
    rchk(8'hD5, 16'hBEEF);
    rchk(8'hD8, 16'h0005);
    otp_flags <= 3'b010;
    rchk(8'hD8, 16'h0002);
    @(posedge sys_clk);
    send <= 1'b1;
    pec_in <= 8'h3C;
    @(posedge sys_clk);
    send <= 1'b0;
    rchk(8'hD6, 16'h003C);
  endtask
  task automatic t_tune;
    wr(8'hDC, 16'h00FF);
    chk(sense_gain_ratio, 3'h0);
    wr(8'hDB, 16'h00E1);
    chk(tuning_unlocked, 1'b1);
    wr(8'hDC, 16'h00FF);
    rchk(8'hDC, 16'h003F);
    chk({sense_gain_ratio, ramp_transconductance_ratio,
      feedback_transconductance_divider}, 6'h3F);
    wr(8'hDD, 16'h00A5);
    chk({adaptive_on_time_disable_continuous, adaptive_on_time_disable_soft_start,
      sense_gain_multiplier, ramp_transconductance_multiplier, min_off_extend,
      min_on_ratio}, 8'hA5);
    rchk(8'hDD, 16'h00A5);
    wr(8'hDB, 16'h00E0);
    rchk(8'hDC, 16'h0000);
  endtask
  task automatic t_page;
    wr(8'h00, 16'h0001);
    rchk(8'hD2, 16'h0000);
    wr(8'h00, 16'h0000);
    rchk(8'hD2, 16'h0002);
    rchk(8'hD7, 16'h0000);
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, 16'h0000);
  endtask
  // A second reset in mid-run must bring back the reset values.
  task automatic t_rst2;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rchk(8'hD3, 16'h0003);
    rchk(8'hD6, 16'h0000);
    rchk(8'hDB, 16'h0000);
    chk(tuning_unlocked, 1'b0);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_limit;
    t_addr;
    t_ro;
    t_tune;
    t_page;
    t_rst2;
    print_verdict;
  end
  // The run needs about 85 cycles; this cuts a hang short at 2000.
  initial begin
    #(2000 * 50);
    fail_count++;
    print_verdict;
  end
endmodule
